/* clkdist_regs.svh */
// register indexes, field positions and reset values of the clock divider block
`ifndef CLKDIST_REGS_SVH
`define CLKDIST_REGS_SVH
// =====================================================================
// register indexes (byte address is four times the index)
`define IDX_SWALLOW      8'h04
`define IDX_MAIN_UPPER   8'h05
`define IDX_MAIN_LOWER   8'h06
`define IDX_PRESCALER    8'h0A
`define IDX_REF_UPPER    8'h0B
`define IDX_REF_LOWER    8'h0C
`define IDX_INPUT_SEL    8'h45
`define IDX_POWER        8'h46
`define IDX_CHAN_PD      8'h47
`define IDX_CHAN_BASE    8'h48
`define IDX_CHAN_LAST    8'h4F
`define IDX_DELAY        8'h50
// =====================================================================
// field positions
`define PRE_MODE_LSB     2
`define PRE_MODE_MSB     4
`define PRE_BYPASS_BIT   6
`define SEL_FIRST_BIT    0
`define PWR_PLL_OFF_BIT  0
// =====================================================================
// reset values
`define RST_PRESCALER    8'h00
`define RST_REF          8'h00
`define RST_MAIN         8'h00
`define RST_SWALLOW      8'h00
`define RST_INPUT_SEL    8'h01
`define RST_POWER        8'h00
`define RST_CHAN_PD      8'h00
`define RST_CHAN_CFG     15'h0000
`define RST_DELAY        8'h00
`endif

/* clkdist_pkg.sv */
// types shared by the clock divider block
package clkdist_pkg;
   // prescaler mode codes
   typedef enum logic [2:0] {
      PRE_FD1  = 3'b000,
      PRE_FD2  = 3'b001,
      PRE_DM2  = 3'b010,
      PRE_DM4  = 3'b011,
      PRE_DM8  = 3'b100,
      PRE_DM16 = 3'b101,
      PRE_DM32 = 3'b110,
      PRE_FD3  = 3'b111
   } presc_mode_e;
   // the two phase detector inputs
   typedef struct packed {
      logic ref_pulse;
      logic fb_pulse;
   } pfd_s;
   // one output channel setting: high time-1, phase start, divide-1
   typedef struct packed {
      logic [4:0] high_m1;
      logic [4:0] phase;
      logic [4:0] div_m1;
   } chan_cfg_s;
endpackage

/* clkdist_core.sv */
// divider, input routing and output dividers of the clock chip, with apb registers
// Notes on behaviour
// - feedback divider counts only the vco clock input, never the first input.
// - first input feeds distribution by default; select bit 0 cleared picks vco.
// - reference divider is a 14-bit counter dividing by 1 to 16383.
// - reference divide value zero acts as divide by one.
// - reference value: six upper bits low in one register, eight in next.
// - divided reference pulse is one phase detector input.
// - feedback divider: 3-bit prescaler mode, 6-bit swallow, 13-bit main counter.
// - fixed mode codes 000, 001, 111 divide by 1, 2, 3 (bits 4:2).
// - dual modulus codes 010..110 give P of 2,4,8,16,32 with P+1.
// - in fixed mode the swallow counter is ignored; main may be bypassed.
// - each output divides the selected clock by 1 to 32.
// - each output has selectable duty cycle and phase.
// - distribution only: either input selectable through the input mux.
// - pll section can be powered off; distribution then runs from input.
// - each output channel can be powered down by register.
// - only outputs five and six pass through the variable delay stage.
// - feedback total is P times main plus swallow (P times main in fixed mode), to detector second input.
// - main counter takes 1 to 8191; reset value zero acts as one.
// - prescaler register bit 6 bypasses main counter, main count one.
`timescale 1ns/1ps
`include "clkdist_regs.svh"
module clkdist_core (
   // apb slave
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // clock inputs, sampled on pclk
   input  wire logic                    reference_input,
   input  wire logic                    first_clock_input,
   input  wire logic                    vco_clock_input,
   // phase detector inputs and outputs
   output clkdist_pkg::pfd_s            pfd_out,
   output logic [7:0]                   dist_out
);
   import clkdist_pkg::*;

   // =====================================================================
   // functions
   // prescaler base modulus P for a mode code
   function automatic logic [5:0] presc_p(input logic [2:0] m);
      unique case (presc_mode_e'(m))
         PRE_FD1:  presc_p = 6'h01;
         PRE_FD2:  presc_p = 6'h02;
         PRE_FD3:  presc_p = 6'h03;
         PRE_DM2:  presc_p = 6'h02;
         PRE_DM4:  presc_p = 6'h04;
         PRE_DM8:  presc_p = 6'h08;
         PRE_DM16: presc_p = 6'h10;
         PRE_DM32: presc_p = 6'h20;
      endcase
   endfunction
   // a divide value of zero counts as one
   function automatic logic [13:0] at_least_one(input logic [13:0] v);
      at_least_one = (v == 14'h0000) ? 14'h0001 : v;
   endfunction

   // =====================================================================
   // registers
   logic [7:0]  prescaler_control_r;
   logic [7:0]  ref_divider_upper_r;
   logic [7:0]  ref_divider_lower_r;
   logic [7:0]  clock_input_select_r;
   logic [7:0]  swallow_r;
   logic [7:0]  main_upper_r;
   logic [7:0]  main_lower_r;
   logic [7:0]  power_r;
   logic [7:0]  chan_pd_r;
   logic [7:0]  delay_r;
   chan_cfg_s   chan_cfg_r [8];
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   // apb decode
   wire  [7:0]  idx      = paddr[9:2];
   wire         in_chan  = (idx >= `IDX_CHAN_BASE) && (idx <= `IDX_CHAN_LAST) && (paddr[11:10] == 2'b00);
   wire  [2:0]  chan_sel = idx[2:0];
   wire         mapped   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                           (in_chan || idx == `IDX_SWALLOW || idx == `IDX_MAIN_UPPER ||
                            idx == `IDX_MAIN_LOWER || idx == `IDX_PRESCALER || idx == `IDX_REF_UPPER ||
                            idx == `IDX_REF_LOWER || idx == `IDX_INPUT_SEL || idx == `IDX_POWER ||
                            idx == `IDX_CHAN_PD || idx == `IDX_DELAY);
   wire         setup    = psel && !penable;
   wire         wr_done  = psel && penable && pready_r && pwrite && !pslverr_r;
   wire         wr_lo    = wr_done && pstrb[0];
   wire         wr_hi    = wr_done && pstrb[1];

   // read selection
   wire  [31:0] rd_chan  = {17'h00000, chan_cfg_r[chan_sel]};
   wire  [31:0] rd_data  =
      in_chan                    ? rd_chan :
      (idx == `IDX_SWALLOW)      ? {24'h000000, swallow_r} :
      (idx == `IDX_MAIN_UPPER)   ? {24'h000000, main_upper_r} :
      (idx == `IDX_MAIN_LOWER)   ? {24'h000000, main_lower_r} :
      (idx == `IDX_PRESCALER)    ? {24'h000000, prescaler_control_r} :
      (idx == `IDX_REF_UPPER)    ? {24'h000000, ref_divider_upper_r} :
      (idx == `IDX_REF_LOWER)    ? {24'h000000, ref_divider_lower_r} :
      (idx == `IDX_INPUT_SEL)    ? {24'h000000, clock_input_select_r} :
      (idx == `IDX_POWER)        ? {24'h000000, power_r} :
      (idx == `IDX_CHAN_PD)      ? {24'h000000, chan_pd_r} :
      (idx == `IDX_DELAY)        ? {24'h000000, delay_r} : 32'h00000000;

   // bus answer: ready in the first access cycle, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && !mapped;
         prdata_r  <= (setup && mapped && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   // byte-wide register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_control_r  <= `RST_PRESCALER;
         ref_divider_upper_r  <= `RST_REF;
         ref_divider_lower_r  <= `RST_REF;
         clock_input_select_r <= `RST_INPUT_SEL;
         swallow_r            <= `RST_SWALLOW;
         main_upper_r         <= `RST_MAIN;
         main_lower_r         <= `RST_MAIN;
         power_r              <= `RST_POWER;
         chan_pd_r            <= `RST_CHAN_PD;
         delay_r              <= `RST_DELAY;
      end else if (wr_lo) begin
         if (idx == `IDX_PRESCALER)  prescaler_control_r  <= pwdata[7:0];
         if (idx == `IDX_REF_UPPER)  ref_divider_upper_r  <= {2'b00, pwdata[5:0]};
         if (idx == `IDX_REF_LOWER)  ref_divider_lower_r  <= pwdata[7:0];
         if (idx == `IDX_INPUT_SEL)  clock_input_select_r <= pwdata[7:0];
         if (idx == `IDX_SWALLOW)    swallow_r            <= {2'b00, pwdata[5:0]};
         if (idx == `IDX_MAIN_UPPER) main_upper_r         <= {3'b000, pwdata[4:0]};
         if (idx == `IDX_MAIN_LOWER) main_lower_r         <= pwdata[7:0];
         if (idx == `IDX_POWER)      power_r              <= pwdata[7:0];
         if (idx == `IDX_CHAN_PD)    chan_pd_r            <= pwdata[7:0];
         if (idx == `IDX_DELAY)      delay_r              <= pwdata[7:0];
      end
   end

   // channel settings, 15 bits over two byte lanes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) chan_cfg_r[i] <= `RST_CHAN_CFG;
      end else if (in_chan) begin
         if (wr_lo) chan_cfg_r[chan_sel][7:0]  <= pwdata[7:0];
         if (wr_hi) chan_cfg_r[chan_sel][14:8] <= pwdata[14:8];
      end
   end

   // =====================================================================
   // input sampling and edge detection
   logic ref_prev_r;
   logic vco_prev_r;
   logic sel_prev_r;
   wire  pll_off   = power_r[`PWR_PLL_OFF_BIT];
   wire  sel_first = clock_input_select_r[`SEL_FIRST_BIT];
   wire  sel_clk   = sel_first ? first_clock_input : vco_clock_input;
   wire  ref_rise  = reference_input && !ref_prev_r;
   wire  vco_rise  = vco_clock_input && !vco_prev_r;
   wire  sel_rise  = sel_clk && !sel_prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_r <= 1'b0;
         vco_prev_r <= 1'b0;
         sel_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= reference_input;
         vco_prev_r <= vco_clock_input;
         sel_prev_r <= sel_clk;
      end
   end

   // =====================================================================
   // reference divider
   logic [13:0] ref_cnt_r;
   logic        ref_pulse_r;
   wire  [13:0] r_eff    = at_least_one({ref_divider_upper_r[5:0], ref_divider_lower_r});
   wire         ref_wrap = ref_rise && (ref_cnt_r >= r_eff - 14'h0001);

   // counts reference edges, one pulse per r_eff edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_r   <= 14'h0000;
         ref_pulse_r <= 1'b0;
      end else if (pll_off) begin
         ref_cnt_r   <= 14'h0000;
         ref_pulse_r <= 1'b0;
      end else begin
         ref_pulse_r <= ref_wrap;
         if (ref_wrap)      ref_cnt_r <= 14'h0000;
         else if (ref_rise) ref_cnt_r <= ref_cnt_r + 14'h0001;
      end
   end

   // =====================================================================
   // feedback divider: prescaler, swallow and main counters
   logic [5:0]  pre_cnt_r;
   logic [5:0]  a_cnt_r;
   logic [12:0] b_cnt_r;
   logic        fb_pulse_r;
   wire  [2:0]  pre_mode  = prescaler_control_r[`PRE_MODE_MSB:`PRE_MODE_LSB];
   wire         dm_mode   = (pre_mode != PRE_FD1) && (pre_mode != PRE_FD2) && (pre_mode != PRE_FD3);
   wire  [5:0]  p_val     = presc_p(pre_mode);
   wire         use_p1    = dm_mode && (a_cnt_r < swallow_r[5:0]);
   wire  [5:0]  pre_last  = use_p1 ? p_val : p_val - 6'h01;
   wire         pre_wrap  = vco_rise && (pre_cnt_r >= pre_last);
   wire         bypass    = prescaler_control_r[`PRE_BYPASS_BIT];
   wire  [13:0] b_raw     = at_least_one({1'b0, main_upper_r[4:0], main_lower_r});
   wire  [12:0] b_eff     = bypass ? 13'h0001 : b_raw[12:0];
   wire         b_wrap    = pre_wrap && (b_cnt_r >= b_eff - 13'h0001);

   // total per cycle is P*main + swallow in dual modulus modes, P*main in fixed modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r  <= 6'h00;
         a_cnt_r    <= 6'h00;
         b_cnt_r    <= 13'h0000;
         fb_pulse_r <= 1'b0;
      end else if (pll_off) begin
         pre_cnt_r  <= 6'h00;
         a_cnt_r    <= 6'h00;
         b_cnt_r    <= 13'h0000;
         fb_pulse_r <= 1'b0;
      end else begin
         fb_pulse_r <= b_wrap;
         if (pre_wrap)      pre_cnt_r <= 6'h00;
         else if (vco_rise) pre_cnt_r <= pre_cnt_r + 6'h01;
         if (b_wrap) begin
            b_cnt_r <= 13'h0000;
            a_cnt_r <= 6'h00;
         end else if (pre_wrap) begin
            b_cnt_r <= b_cnt_r + 13'h0001;
            if (use_p1) a_cnt_r <= a_cnt_r + 6'h01;
         end
      end
   end

   // =====================================================================
   // output dividers with duty and phase
   logic [4:0] ch_cnt_r [8];
   logic [7:0] ch_out_r;
   logic [7:0] dly5_r;
   logic [7:0] dly6_r;
   logic [7:0] dist_r;

   // a channel write restarts its counter at the phase value held before the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) ch_cnt_r[i] <= 5'h00;
         ch_out_r <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (chan_pd_r[i]) begin
               ch_cnt_r[i] <= chan_cfg_r[i].phase;
               ch_out_r[i] <= 1'b0;
            end else if (wr_done && in_chan && chan_sel == 3'(i)) begin
               ch_cnt_r[i] <= chan_cfg_r[i].phase;
            end else if (chan_cfg_r[i].div_m1 == 5'h00) begin
               ch_out_r[i] <= sel_clk;
            end else if (sel_rise) begin
               ch_cnt_r[i] <= (ch_cnt_r[i] >= chan_cfg_r[i].div_m1) ? 5'h00 : ch_cnt_r[i] + 5'h01;
               ch_out_r[i] <= (ch_cnt_r[i] <= chan_cfg_r[i].high_m1);
            end
         end
      end
   end

   // delay lines on outputs five and six only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly5_r <= 8'h00;
         dly6_r <= 8'h00;
      end else begin
         dly5_r <= {dly5_r[6:0], ch_out_r[5]};
         dly6_r <= {dly6_r[6:0], ch_out_r[6]};
      end
   end

   wire d5 = dly5_r[delay_r[2:0]];
   wire d6 = dly6_r[delay_r[6:4]];

   // final output flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dist_r <= 8'h00;
      else          dist_r <= {ch_out_r[7], d6, d5, ch_out_r[4:0]};
   end

   // =====================================================================
   // outputs
   assign prdata           = prdata_r;
   assign pready           = pready_r;
   assign pslverr          = pslverr_r;
   assign pfd_out          = pfd_s'{ref_pulse: ref_pulse_r, fb_pulse: fb_pulse_r};
   assign dist_out         = dist_r;

   // =====================================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // divider and routing checks
   ref_pulse_cause_a: assert property (ref_pulse_r |-> $past(ref_wrap))
      else $error("reference pulse without a divider wrap");
   ref_div_one_a: assert property ((r_eff == 14'h0001 && !pll_off && ref_rise) |=> ref_pulse_r)
      else $error("divide by one missed a reference edge");
   ref_cnt_range_a: assert property (ref_rise |=> ref_cnt_r < $past(r_eff))
      else $error("reference count beyond divide value");
   fb_vco_only_a: assert property ((!vco_rise) |=> $stable(pre_cnt_r) || pll_off)
      else $error("prescaler moved without a vco edge");
   fd_no_swallow_a: assert property ((!dm_mode && !pll_off) |=> (a_cnt_r == $past(a_cnt_r) || a_cnt_r == 6'h00))
      else $error("swallow counter advanced in fixed mode");
   bypass_main_a: assert property ((bypass && pre_wrap && !pll_off) |=> fb_pulse_r)
      else $error("bypass did not pulse per prescaler period");
   pll_off_quiet_a: assert property (pll_off |=> !pfd_out.ref_pulse && !pfd_out.fb_pulse)
      else $error("pulses while pll powered off");
   chan_pd_low_a: assert property (chan_pd_r[0] [*3] |-> !dist_out[0])
      else $error("powered down channel still toggles");
   mux_sel_a: assert property (sel_first |-> sel_clk == first_clock_input)
      else $error("input mux does not follow select bit");

   // prescaler count stays within its modulus after each vco edge
   pre_range_a: assert property ((vco_rise && !pll_off) |=> pre_cnt_r <= $past(p_val))
      else $error("prescaler count beyond its modulus");
   // a feedback wrap restarts swallow and main counters together
   fb_restart_a: assert property ((b_wrap && !pll_off) |=> a_cnt_r == 6'h00 && b_cnt_r == 13'h0000)
      else $error("feedback counters not restarted after a wrap");
   // reference count moves only on a reference edge
   ref_hold_a: assert property ((!ref_rise && !pll_off) |=> $stable(ref_cnt_r))
      else $error("reference count moved without a reference edge");
   // detector pulses last one cycle each
   ref_pulse_one_a: assert property (ref_pulse_r |=> !ref_pulse_r)
      else $error("reference pulse longer than one cycle");
   fb_pulse_one_a: assert property (fb_pulse_r |=> !fb_pulse_r)
      else $error("feedback pulse longer than one cycle");
   // outputs other than five and six leave one flop after their divider
   undelayed_out_a: assert property ({dist_out[7], dist_out[4:0]} == $past({ch_out_r[7], ch_out_r[4:0]}))
      else $error("undelayed output does not follow its divider");
   // powered down channels drive low on the next edge
   pd_all_low_a: assert property ((chan_pd_r != 8'h00) |=> (ch_out_r & $past(chan_pd_r)) == 8'h00)
      else $error("powered down channel divider output not low");
   // a channel write restarts that channel at the phase value it held before the write
   phase_load_a: assert property (
      (wr_done && in_chan) |=> ch_cnt_r[$past(chan_sel)] == $past(chan_cfg_r[chan_sel].phase))
      else $error("channel write did not reload its phase");

   // main scenarios reached
   cov_fb_dm_c:   cover property (dm_mode && b_wrap);
   cov_chan_pd_c: cover property (chan_pd_r[0] && !dist_out[0]);
   cov_fb_fd_c:   cover property (!dm_mode && bypass && b_wrap);
   cov_ref_div_c: cover property (r_eff > 14'h0002 && ref_wrap);
   cov_vco_dist_c: cover property (!sel_first && sel_rise);
endmodule

/* clkdist_far_model.sv */
// behavioural reference source, spare input clock and external oscillator
`timescale 1ns/1ps
module clkdist_far_model #(
   parameter int REF_HALF_NS   = 60,
   parameter int VCO_HALF_NS   = 60,
   parameter int FIRST_HALF_NS = 100,
   parameter int START_NS      = 7
) (
   // clocks toward the block
   output logic reference_input,
   output logic first_clock_input,
   output logic vco_clock_input
);
   // =====================================================================
   // free running sources
   // edges never land on a bus clock edge, rates stay below half of it
   initial begin
      reference_input = 1'b0;
      #(START_NS);
      forever #(REF_HALF_NS) reference_input = ~reference_input;
   end
   // oscillator kept far under every prescaler limit
   initial begin
      vco_clock_input = 1'b0;
      #(START_NS);
      forever #(VCO_HALF_NS) vco_clock_input = ~vco_clock_input;
   end
   // second source at another rate so routing faults show
   initial begin
      first_clock_input = 1'b0;
      #(START_NS);
      forever #(FIRST_HALF_NS) first_clock_input = ~first_clock_input;
   end
endmodule

/* tb_clkdist_core.sv */
// self-checking bench: divider ratios, input routing, output dividers, apb registers
`timescale 1ns/1ps
`include "clkdist_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("BAD t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_clkdist_core;
   import clkdist_pkg::*;
   typedef struct {
      logic [2:0]  mode;
      logic        byp;
      logic [5:0]  swal;
      logic [12:0] main;
      logic [13:0] refv;
      int          n_exp;
      int          r_exp;
   } row_s;
   // =====================================================================
   // signals
   logic              pclk, presetn, psel, penable, pwrite;
   logic [7:0]        idx;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, er;
   logic              reference_input, first_clock_input, vco_clock_input;
   pfd_s              pfd_out;
   logic [7:0]        dist_out;
   int                err_total, compares, i, m;
   logic [7:0]        didx [5] = '{`IDX_PRESCALER, `IDX_REF_UPPER, `IDX_MAIN_LOWER, `IDX_INPUT_SEL, `IDX_POWER};
   logic [7:0]        dval [5] = '{`RST_PRESCALER, `RST_REF, `RST_MAIN, `RST_INPUT_SEL, `RST_POWER};
   row_s              rows [9] = '{
      '{PRE_FD1,  1'b1, 6'h00, 13'h0000, 14'h0000, 1,   1},
      '{PRE_FD2,  1'b1, 6'h05, 13'h0000, 14'h0001, 2,   1},
      '{PRE_FD3,  1'b0, 6'h09, 13'h0003, 14'h0005, 9,   5},
      '{PRE_DM2,  1'b0, 6'h01, 13'h0003, 14'h0105, 7,   261},
      '{PRE_DM4,  1'b0, 6'h01, 13'h0003, 14'h0003, 13,  3},
      '{PRE_DM8,  1'b0, 6'h02, 13'h0003, 14'h0002, 26,  2},
      '{PRE_DM16, 1'b0, 6'h00, 13'h0003, 14'h0004, 48,  4},
      '{PRE_DM32, 1'b0, 6'h01, 13'h0003, 14'h2003, 97,  8195},
      '{PRE_FD1,  1'b0, 6'h00, 13'h0105, 14'h0002, 261, 2}
   };
   // =====================================================================
   // design and far side
   clkdist_core DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr({2'b00, idx, 2'b00}), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reference_input(reference_input),
      .first_clock_input(first_clock_input), .vco_clock_input(vco_clock_input),
      .pfd_out(pfd_out), .dist_out(dist_out)
   );
   clkdist_far_model far_src (
      .reference_input(reference_input),
      .first_clock_input(first_clock_input),
      .vco_clock_input(vco_clock_input)
   );
   // =====================================================================
   // clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // one apb transfer, request held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      idx <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) `CHK(pready, 1'b1)
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // selected input edges between two events: 0 ref pulse, 1 fb pulse, 2/3 output rise
   task automatic measure(input int which, output int res);
      int   cnt, seen, k;
      logic src, prev, hit, dprev;
      cnt = 0;
      seen = 0;
      res = -1;
      prev = 1'b1;
      dprev = 1'b1;
      for (k = 0; k < 60000 && seen < 2; k++) begin
         @(posedge pclk);
         #1;
         src = (which == 0) ? reference_input : (which == 2) ? first_clock_input : vco_clock_input;
         hit = (which == 0) ? pfd_out.ref_pulse : (which == 1) ? pfd_out.fb_pulse : (dist_out[0] & ~dprev);
         dprev = dist_out[0];
         if (src === 1'b1 && prev === 1'b0) cnt++;
         prev = src;
         if (hit === 1'b1) begin
            seen++;
            res = cnt;
            cnt = 0;
         end
      end
      if (seen < 2) res = -1;
      @(posedge pclk);
   endtask
   // samples in 300 cycles where detector pulses (0) or output 0 (1) are not low
   task automatic count_high(input int which, output int n);
      n = 0;
      repeat (300) begin
         @(posedge pclk);
         #1;
         if (which == 0) n += (pfd_out !== 2'b00);
         else n += (dist_out[0] !== 1'b0);
      end
      @(posedge pclk);
   endtask
   // samples in the last 296 of 300 cycles where output 5 differs from output 4 seen lag cycles before
   task automatic count_lag(input int lag, output int n);
      logic [3:0] hist;
      hist = 4'h0;
      n = 0;
      for (int k = 0; k < 300; k++) begin
         @(posedge pclk);
         #1;
         if (k >= 4) n += (dist_out[5] !== hist[lag - 1]);
         hist = {hist[2:0], dist_out[4]};
      end
      @(posedge pclk);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // =====================================================================
   // watchdog
   initial begin
      #(40 * 95000);
      err_total++;
      $display("BAD t=%0t run did not finish", $time);
      summarize();
   end
   // =====================================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      idx = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      compares = 0;
      do_reset();
      // divider table
      for (i = 0; i < 9; i++) begin
         apb(1'b1, `IDX_PRESCALER, {26'h0, rows[i].byp, rows[i].mode, 2'b00}, rd, er);
         apb(1'b1, `IDX_SWALLOW, {26'h0, rows[i].swal}, rd, er);
         apb(1'b1, `IDX_MAIN_UPPER, {27'h0, rows[i].main[12:8]}, rd, er);
         apb(1'b1, `IDX_MAIN_LOWER, {24'h0, rows[i].main[7:0]}, rd, er);
         apb(1'b1, `IDX_REF_UPPER, {26'h0, rows[i].refv[13:8]}, rd, er);
         apb(1'b1, `IDX_REF_LOWER, {24'h0, rows[i].refv[7:0]}, rd, er);
         measure(0, m);
         `CHK(m, rows[i].r_exp)
         measure(1, m);
         `CHK(m, rows[i].n_exp)
         $display("divider row %0d done", i);
      end
      // reset in mid-run, register defaults
      do_reset();
      for (i = 0; i < 5; i++) begin
         apb(1'b0, didx[i], 32'h0, rd, er);
         `CHK(rd, {24'h0, dval[i]})
      end
      apb(1'b1, `IDX_REF_UPPER, 32'h0000003F, rd, er);
      apb(1'b0, `IDX_REF_UPPER, 32'h0, rd, er);
      `CHK(rd, 32'h0000003F)
      apb(1'b0, 8'h20, 32'h0, rd, er);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      $display("reset and registers done");
      // pll section off, distribution alone, pll back on at the end
      apb(1'b1, `IDX_POWER, 32'h00000001, rd, er);
      count_high(0, m);
      `CHK(m, 0)
      apb(1'b1, `IDX_CHAN_BASE, 32'h00000403, rd, er);
      measure(2, m);
      `CHK(m, 4)
      apb(1'b1, `IDX_INPUT_SEL, 32'h0, rd, er);
      apb(1'b1, `IDX_CHAN_BASE, 32'h0000001F, rd, er);
      measure(3, m);
      `CHK(m, 32)
      apb(1'b1, `IDX_CHAN_PD, 32'h00000001, rd, er);
      count_high(1, m);
      `CHK(m, 0)
      apb(1'b1, `IDX_DELAY, 32'h00000001, rd, er);
      count_lag(2, m);
      `CHK(m, 0)
      apb(1'b1, `IDX_POWER, 32'h0, rd, er);
      measure(1, m);
      `CHK(m, 1)
      $display("distribution and power done");
      summarize();
   end
endmodule
